// file: rtl/git_core.sv
/*
  Pin interrupt detection, wake request and frame request sequencing,
  with an APB register file.
  Assumes pins synchronous to mclk; a frame sink that pulls frame_ready.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module git_core
  import git_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // pins and system
  input  wire logic [8:0]  pin_in,
  input  wire logic        standby,
  input  wire logic        net_period_tick,
  input  wire logic        wakeup_tick,
  // frame request
  output git_frame_t       frame,
  output logic             frame_valid,
  input  wire logic        frame_ready,
  output logic             wake_req
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] dir_reg, irq_en_reg, telem_reg, src_reg;
  logic [7:0] wake_div_reg, rcpt_lo_reg, rcpt_hi_reg;
  logic [5:0] prev_reg, pend_reg;
  logic       dig_pend_reg, ana_pend_reg;
  git_state_t state_reg, state_next;
  git_frame_t frame_next;
  logic [31:0] rdata_next;

  function automatic logic [2:0] lowest(input logic [5:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_IRQ_PINS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[2:0];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire [9:0] idx      = paddr[11:2];
  wire       acc      = psel && penable && clk_en;
  wire       wr       = acc && pwrite;
  wire       hit      = (idx == IDX_DIRECTION) || (idx == IDX_IRQ_EN) ||
                        (idx == IDX_TELEM) || (idx == IDX_SRC_INFO) ||
                        (idx == IDX_WAKE_DIV) || (idx == IDX_RCPT_LOW) ||
                        (idx == IDX_RCPT_HIGH) || (idx == IDX_STATUS);
  // input direction required for an interrupt source
  wire [5:0] armed    = irq_en_reg[5:0] & dir_reg[5:0];
  wire [5:0] cur      = pin_in[5:0];
  wire [5:0] rise     = cur & ~prev_reg;
  wire [5:0] fall     = ~cur & prev_reg;
  wire [5:0] edge_hit = armed & ((rise & MASK_RISE) |
                                 (fall & MASK_FALL) |
                                 ((rise | fall) & MASK_BOTH));
  // with wake-up divider above one, only wake ticks trigger telemetry
  wire       tele_tick = (wake_div_reg > 8'h01) ? wakeup_tick
                                                : net_period_tick;
  wire       tele_on  = telem_reg[1:0] != TELEM_OFF;
  wire [15:0] rcpt    = {rcpt_hi_reg, rcpt_lo_reg};
  wire       take     = frame_valid && frame_ready;
  wire       busy     = frame_valid && !frame_ready;

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (idx)
      IDX_DIRECTION: rdata_next = {24'h0, dir_reg};
      IDX_IRQ_EN:    rdata_next = {24'h0, irq_en_reg};
      IDX_TELEM:     rdata_next = {24'h0, telem_reg};
      IDX_SRC_INFO:  rdata_next = {24'h0, src_reg};
      IDX_WAKE_DIV:  rdata_next = {24'h0, wake_div_reg};
      IDX_RCPT_LOW:  rdata_next = {24'h0, rcpt_lo_reg};
      IDX_RCPT_HIGH: rdata_next = {24'h0, rcpt_hi_reg};
      IDX_STATUS:    rdata_next = {22'h0, dig_pend_reg, ana_pend_reg,
                                   2'(state_reg), pend_reg};
      default:       rdata_next = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // frame sequencer: irq first, then digital, then analog
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    frame_next = frame;
    if (!busy) begin
      state_next = GIT_IDLE;
      if (pend_reg != 6'h00) begin
        state_next = GIT_IRQ;
        frame_next.recipient = rcpt;
        if (src_reg[0]) begin
          frame_next.kind    = GIT_KIND_IRQ_SRC;
          frame_next.payload = {5'h00, lowest(pend_reg)};
        end else begin
          frame_next.kind    = GIT_KIND_IRQ_ALL;
          frame_next.payload = pin_in[7:0];
        end
      end else if (dig_pend_reg) begin
        state_next = GIT_DIG;
        frame_next = '{kind: GIT_KIND_DIG, recipient: rcpt,
                       payload: pin_in[7:0]};
      end else if (ana_pend_reg) begin
        state_next = GIT_ANA;
        frame_next = '{kind: GIT_KIND_ANA, recipient: rcpt,
                       payload: {2'h0, pin_in[5:0]}};
      end
    end
  end

  wire sel_irq = !busy && (pend_reg != 6'h00);
  wire sel_dig = !busy && !sel_irq && dig_pend_reg;
  wire sel_ana = !busy && !sel_irq && !dig_pend_reg && ana_pend_reg;
  wire [5:0] clr_irq = sel_irq ? (src_reg[0] ?
                       6'(6'h01 << lowest(pend_reg)) : pend_reg) : 6'h00;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dir_reg      <= RST_DIRECTION;
      irq_en_reg   <= RST_BYTE;
      telem_reg    <= RST_BYTE;
      src_reg      <= RST_BYTE;
      wake_div_reg <= RST_WAKE_DIV;
      rcpt_lo_reg  <= RST_BYTE;
      rcpt_hi_reg  <= RST_BYTE;
    end else if (wr) begin
      if (idx == IDX_DIRECTION) dir_reg <= pwdata[7:0];
      if (idx == IDX_IRQ_EN)    irq_en_reg <= pwdata[7:0];
      if (idx == IDX_TELEM)     telem_reg <= pwdata[7:0];
      if (idx == IDX_SRC_INFO)  src_reg <= pwdata[7:0];
      if (idx == IDX_WAKE_DIV)  wake_div_reg <= pwdata[7:0];
      if (idx == IDX_RCPT_LOW)  rcpt_lo_reg <= pwdata[7:0];
      if (idx == IDX_RCPT_HIGH) rcpt_hi_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      // one wait state: ready rises in the second access cycle
      pready  <= psel && penable && !pready;
      prdata  <= rdata_next;
      pslverr <= psel && penable && !pready && !hit;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_reg     <= 6'h00;
      pend_reg     <= 6'h00;
      dig_pend_reg <= 1'b0;
      ana_pend_reg <= 1'b0;
      state_reg    <= GIT_IDLE;
      frame        <= '{kind: GIT_KIND_IRQ_ALL, recipient: 16'h0000,
                        payload: 8'h00};
      frame_valid  <= 1'b0;
      wake_req     <= 1'b0;
    end else if (clk_en) begin
      prev_reg  <= cur;
      // a new edge wins over the clear of the same pin
      pend_reg  <= (pend_reg & ~clr_irq) | edge_hit;
      wake_req  <= standby && (edge_hit != 6'h00);
      dig_pend_reg <= (dig_pend_reg && !sel_dig) || (tele_tick && tele_on &&
                      telem_reg[0]);
      ana_pend_reg <= (ana_pend_reg && !sel_ana) || (tele_tick && tele_on &&
                      telem_reg[1]);
      state_reg    <= state_next;
      frame        <= frame_next;
      frame_valid  <= busy || (state_next != GIT_IDLE);
    end
  end
  wire unused_ok = &{1'b0, take, pin_in[8], pwdata[31:8]};
endmodule
`default_nettype wire

// file: include/git_pkg.sv
/*
  Constants, types and register map for the pin interrupt and telemetry block.
  Assumes an APB slave with 32-bit data and a 40 MHz system clock.
*/
// Summary of operation
// - enable bit 0 plain pin, 1 interrupt
// - pins three, four interrupt on rising edge
// - pins five, six interrupt on falling edge
// - pins seven, eight interrupt on both edges
// - qualifying edge sends status frame to recipient
// - telemetry sent each network period unrequested
// - setting picks digital, analog or both
// - setting three sends two separate frames
// - with periodic wakeup, once per wakeup
// - source info 0 carries all pin states
// - source info 1 names pin, not edge
package git_pkg;
  // ----------------------------------------------------------------
  // register map (printed offsets are indexes, byte address = 4*index)
  // ----------------------------------------------------------------
  localparam logic [9:0]  IDX_DIRECTION  = 10'h159;
  localparam logic [9:0]  IDX_IRQ_EN     = 10'h15A;
  localparam logic [9:0]  IDX_TELEM      = 10'h15B;
  localparam logic [9:0]  IDX_SRC_INFO   = 10'h15C;
  localparam logic [9:0]  IDX_WAKE_DIV   = 10'h155;
  localparam logic [9:0]  IDX_RCPT_LOW   = 10'h13B;
  localparam logic [9:0]  IDX_RCPT_HIGH  = 10'h13C;
  localparam logic [9:0]  IDX_STATUS     = 10'h1F0;
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [7:0]  RST_DIRECTION  = 8'hFF;
  localparam logic [7:0]  RST_WAKE_DIV   = 8'h01;
  // ----------------------------------------------------------------
  // pin groups: bit n-3 of the enable register is pin n
  // ----------------------------------------------------------------
  localparam logic [5:0]  MASK_RISE      = 6'h03;
  localparam logic [5:0]  MASK_FALL      = 6'h0C;
  localparam logic [5:0]  MASK_BOTH      = 6'h30;
  localparam int          NUM_IRQ_PINS   = 6;
  localparam logic [1:0]  TELEM_OFF      = 2'h0;
  localparam logic [1:0]  TELEM_DIG      = 2'h1;
  localparam logic [1:0]  TELEM_ANA      = 2'h2;
  localparam logic [1:0]  TELEM_BOTH     = 2'h3;
  // ----------------------------------------------------------------
  // frame request carrier
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GIT_KIND_IRQ_ALL = 2'b00,
    GIT_KIND_IRQ_SRC = 2'b01,
    GIT_KIND_DIG     = 2'b10,
    GIT_KIND_ANA     = 2'b11
  } git_kind_t;
  typedef struct packed {
    git_kind_t   kind;
    logic [15:0] recipient;
    logic [7:0]  payload;
  } git_frame_t;
  typedef enum logic [1:0] {
    GIT_IDLE = 2'b00,
    GIT_IRQ  = 2'b01,
    GIT_DIG  = 2'b10,
    GIT_ANA  = 2'b11
  } git_state_t;
endpackage

// file: tb/git_properties.sv
/* port properties of git_core: bus answer, frame hold, wake pulse.
   bound from the bench top; sees only the top ports. */
`timescale 1ns/100ps
`default_nettype none
module git_properties
  import git_pkg::*;
(
  // clock, reset, bus
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // standby, frames, wake
  input wire logic        standby,
  input wire git_frame_t  frame,
  input wire logic        frame_valid,
  input wire logic        frame_ready,
  input wire logic        wake_req
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence acc_wait; psel && penable && clk_en && !pready; endsequence
  sequence held; frame_valid && !frame_ready; endsequence
  sequence taken; frame_valid && frame_ready; endsequence
  one_wait_a: assert property (acc_wait |=> pready)
    else $error("no answer after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refusal without ready or with data");
  frame_hold_a: assert property (
    held |=> frame_valid && $stable(frame)) else $error("frame dropped");
  // a queued frame may follow at once, but never repeats the one taken
  frame_gap_a: assert property (
    taken |=> !frame_valid || (frame != $past(frame)))
    else $error("frames not separate");
  wake_cause_a: assert property (wake_req |-> $past(standby))
    else $error("wake outside standby");
  wake_pulse_a: assert property (wake_req |=> !wake_req)
    else $error("wake longer than one cycle");
  src_index_a: assert property (
    frame_valid && frame.kind == GIT_KIND_IRQ_SRC |-> frame.payload < 8'h06)
    else $error("bad source pin index");
endmodule
`default_nettype wire

// file: tb/git_core_tb_top.sv
/* bench top for git_core: random pin edges, telemetry and apb access.
   assumes git_pkg and the checker; frame sink is the bench. */
`timescale 1ns/100ps
`default_nettype none
module git_core_tb_top
  import git_pkg::*;
;
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic        standby, net_tick, wake_tick, frame_valid, frame_ready;
  logic        wake_req, wake_seen, ok, clk_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  pins;
  logic [15:0] rcpt;
  git_frame_t  frame, f;
  int          failures, compares;
  git_core dut (.mclk(mclk), .nrst(nrst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .pin_in(pins),
    .standby(standby), .net_period_tick(net_tick),
    .wakeup_tick(wake_tick), .frame(frame), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .wake_req(wake_req));
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) if (wake_req === 1'b1) wake_seen = 1'b1;
  task finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd  = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      failures++;
      finish_test;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // sink holds ready low until a frame shows, so holding is exercised
  task take;
    ok = 1'b0;
    for (int i = 0; i < 20 && !ok; i++) begin
      @(negedge mclk);
      if (frame_valid === 1'b1) begin
        f  = frame;
        ok = 1'b1;
      end
    end
    @(posedge mclk);
    if (ok) begin
      frame_ready <= 1'b1;
      @(posedge mclk);
      frame_ready <= 1'b0;
    end
  endtask
  task tick(input logic wk);
    if (wk) wake_tick <= 1'b1;
    else net_tick <= 1'b1;
    @(posedge mclk);
    wake_tick <= 1'b0;
    net_tick  <= 1'b0;
    take;
  endtask
  function automatic logic qual(int k, logic r);
    return k < 2 ? r : (k < 4 ? !r : 1'b1);
  endfunction
  initial begin
    logic [7:0] en;
    int         k;
    logic       sb;
    {psel, penable, pwrite, paddr, pwdata, pins} = '0;
    {standby, net_tick, wake_tick, frame_ready, wake_seen, nrst} = '0;
    clk_en = 1'b1;
    void'($urandom(32'hA94C));
    rcpt = 16'($urandom);
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    apb(1'b0, IDX_IRQ_EN, 32'h0);
    chk(rd, {24'h0, RST_BYTE});
    apb(1'b0, IDX_DIRECTION, 32'h0);
    chk(rd, {24'h0, RST_DIRECTION});
    apb(1'b0, 10'h100, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, IDX_RCPT_LOW, {24'h0, rcpt[7:0]});
    apb(1'b1, IDX_RCPT_HIGH, {24'h0, rcpt[15:8]});
    repeat (24) begin
      en = 8'($urandom);
      k  = $urandom % 6;
      sb = 1'($urandom);
      apb(1'b1, IDX_IRQ_EN, {24'h0, en});
      standby <= sb;
      @(posedge mclk);
      wake_seen = 1'b0;
      pins <= {3'($urandom), pins[5:0] ^ (6'h01 << k)};
      @(posedge mclk);
      take;
      chk(ok, en[k] && qual(k, pins[k]));
      if (ok) chk(f, {GIT_KIND_IRQ_ALL, rcpt, pins[7:0]});
      chk(wake_seen, ok && sb);
    end
    apb(1'b1, IDX_IRQ_EN, 32'h0);
    pins[0] <= 1'b0;
    pins[2] <= 1'b1;
    standby <= 1'b0;
    apb(1'b1, IDX_SRC_INFO, 32'h1);
    apb(1'b1, IDX_IRQ_EN, 32'h3F);
    pins[0] <= 1'b1;
    pins[2] <= 1'b0;
    @(posedge mclk);
    take;
    chk(f, {GIT_KIND_IRQ_SRC, rcpt, 8'h00});
    take;
    chk(f, {GIT_KIND_IRQ_SRC, rcpt, 8'h02});
    for (int t = 0; t < 4; t++) begin
      apb(1'b1, IDX_TELEM, 32'(t));
      tick(1'b0);
      chk(ok, t != 0);
      if (t == 2) chk(f, {GIT_KIND_ANA, rcpt, 2'b00, pins[5:0]});
      else if (ok) chk(f[25:8], {GIT_KIND_DIG, rcpt});
      if (t == 3) take;
      if (t == 3) chk(f, {GIT_KIND_ANA, rcpt, 2'b00, pins[5:0]});
    end
    apb(1'b1, IDX_TELEM, 32'h1);
    apb(1'b1, IDX_WAKE_DIV, 32'h2);
    tick(1'b0);
    chk(ok, 1'b0);
    tick(1'b1);
    chk({ok, f[25:24]}, {1'b1, GIT_KIND_DIG});
    // frozen block must ignore a wake tick that would otherwise report
    clk_en <= 1'b0;
    tick(1'b1);
    chk(ok, 1'b0);
    clk_en <= 1'b1;
    @(posedge mclk);
    finish_test;
  end
  initial begin
    #2500000;
    failures++;
    finish_test;
  end
endmodule
bind git_core git_properties u_props (.mclk(mclk), .nrst(nrst),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .standby(standby), .frame(frame),
  .frame_valid(frame_valid), .frame_ready(frame_ready),
  .wake_req(wake_req));
`default_nettype wire
